//--- rtl/aasf_regs.vh
// Constants for the actuator status and alarm flag logic.
`ifndef AASF_REGS_VH
`define AASF_REGS_VH

// System clock rate in hertz (20 MHz).
`define AASF_CLK_HZ 32'h0131_2D00

// Stall detection window in seconds.
`define AASF_STALL_SEC 32'h0000_0004

// Interrupter period limits in seconds.
`define AASF_INT_LOCAL_MIN 14'h0001
`define AASF_INT_LOCAL_MAX 14'h0063
// Four and a half hours expressed in seconds.
`define AASF_INT_EXT_MAX 14'h3F48

// Manual travel needed before the handwheel flag rises, in percent.
`define AASF_HW_DELTA_PCT 7'h01

// Aux input positions.
`define AASF_AUX_OPEN 0
`define AASF_AUX_CLOSE 1
`define AASF_AUX_STOP 2
`define AASF_AUX_ESD 3

// Interrupter sequencer states.
`define AASF_ST_IDLE 2'h0
`define AASF_ST_ON 2'h1
`define AASF_ST_DWELL 2'h2

`endif

//--- rtl/aasf_period_timer.v
// Seconds based period timer used for the interrupter on and off phases.
`timescale 1ns/100ps
`include "aasf_regs.vh"

module aasf_period_timer #(
	parameter CLK_HZ = `AASF_CLK_HZ,
	parameter SEC_W = 14
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_start,
	input wire [SEC_W-1:0] i_secs,
	output reg o_done
);

reg [31:0] pre_reg;
reg [SEC_W-1:0] secs_reg;
reg run_reg;

// A restart reloads both counters so a phase is never shortened.
always @(posedge i_clk) begin
	if (i_rst) begin
		pre_reg <= 32'h0000_0000;
		secs_reg <= {SEC_W{1'b0}};
		run_reg <= 1'b0;
		o_done <= 1'b0;
	end else begin
		o_done <= 1'b0;
		if (i_start) begin
			pre_reg <= 32'h0000_0000;
			secs_reg <= i_secs;
			run_reg <= 1'b1;
		end else if (run_reg) begin
			if (pre_reg == CLK_HZ - 1) begin
				pre_reg <= 32'h0000_0000;
				if (secs_reg <= {{(SEC_W-1){1'b0}}, 1'b1}) begin
					run_reg <= 1'b0;
					o_done <= 1'b1;
				end else begin
					secs_reg <= secs_reg - {{(SEC_W-1){1'b0}}, 1'b1};
				end
			end else begin
				pre_reg <= pre_reg + 32'h0000_0001;
			end
		end
	end
end

endmodule

//--- rtl/aasf_status_flags.v
// Actuator status and alarm flag logic with motor command gating.
//
// Overview of operation
// [R1] Each aux input is separately set to command or report only.
// [R2] Remote use maps aux one open, two close, three stop, four shutdown.
// [R3] Closed contact acts in remote mode; flag follows contact always.
// [R4] Interrupter pulses drive on and dwells off over set travel zone.
// [R5] Locally set on and off periods range from 1 to 99 seconds.
// [R6] Communicator set periods reach up to four and a half hours.
// [R7] Interrupter flag is true while travel dwells under the timer.
// [R8] Blinker flag mirrors the internal relay flasher state.
// [R9] With interlocking, network moves need interlock output and command.
// [R10] Interlock flag is true while interlocking is enabled and the interlock signal is active.
// [R11] Shutdown flag rises on a shutdown request from any source.
// [R12] Control not available is local, local stop or thermostat trip.
// [R13] With mains supervision a lost phase also flags control unavailable.
// [R14] Low battery flag rises when battery falls below critical level.
// [R15] Commanded move without motion for 4 seconds raises stalled flag.
// [R16] Handwheel flag needs manual travel of at least 1 percent.
// [R17] Open thermostat contact stops the motor and raises its flag.
// [R18] After a trip new moves are refused until thermostat resets.
// [R19] Optional setting lets shutdown override the thermostat inhibit.
// [R20] Thermostat flag stays 1 until the contact has reset.
// [R21] Stall timer restarts per new command, clears on motion.
`timescale 1ns/100ps
`include "aasf_regs.vh"

module aasf_status_flags #(
	parameter CLK_HZ = `AASF_CLK_HZ,
	parameter STALL_CYCLES = `AASF_STALL_SEC * `AASF_CLK_HZ,
	parameter SEC_W = 14
) (
	input wire I_CLK,
	input wire I_SYS_RST,
	input wire [3:0] I_AUX_CONTACT,
	input wire [3:0] I_AUX_CTRL_EN,
	input wire I_SEL_REMOTE,
	input wire I_SEL_LOCAL,
	input wire I_SEL_LOCAL_STOP,
	input wire I_LOCAL_OPEN,
	input wire I_LOCAL_CLOSE,
	input wire I_NET_OPEN,
	input wire I_NET_CLOSE,
	input wire I_NET_EMERGENCY_SHUTDOWN,
	input wire I_INTERLOCK_EN,
	input wire I_INTERLOCK_DIGITAL_OUTPUT,
	input wire I_ESD_OPEN_DIR,
	input wire I_ESD_OVERRIDE_THERMO,
	input wire I_THERMO_CLOSED,
	input wire I_MAINS_SUPV_EN,
	input wire [2:0] I_PHASE_OK,
	input wire I_BATTERY_BELOW,
	input wire I_FLASHER,
	input wire I_MOVING,
	input wire [6:0] I_POSITION_PCT,
	input wire I_INT_EN,
	input wire I_INT_EXT_RANGE,
	input wire [6:0] I_INT_OPEN_START_PCT,
	input wire [6:0] I_INT_CLOSE_START_PCT,
	input wire [SEC_W-1:0] I_INT_ON_SEC,
	input wire [SEC_W-1:0] I_INT_OFF_SEC,
	output reg O_MOTOR_OPEN,
	output reg O_MOTOR_CLOSE,
	output reg [3:0] O_AUX_STATUS,
	output reg O_INTERRUPTER,
	output reg O_BLINKER,
	output reg O_INTERLOCK,
	output reg O_EMERGENCY_SHUTDOWN,
	output reg O_CTRL_NOT_AVAIL,
	output reg O_LOW_BATTERY,
	output reg O_STALLED,
	output reg O_HANDWHEEL,
	output reg O_THERMOSTAT
);

// =====================================================================
// Aux inputs
// =====================================================================

wire [3:0] aux_cmd;

genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_aux
		// [R1] [R3] Per input command enable.
		assign aux_cmd[gi] = I_AUX_CTRL_EN[gi] & I_AUX_CONTACT[gi] &
			I_SEL_REMOTE;
	end
endgenerate

// [R2] Remote mapping.
wire aux_open = aux_cmd[`AASF_AUX_OPEN];
wire aux_close = aux_cmd[`AASF_AUX_CLOSE];
wire aux_stop = aux_cmd[`AASF_AUX_STOP];
wire aux_esd = aux_cmd[`AASF_AUX_ESD];

// =====================================================================
// Command sources
// =====================================================================

// [R9] Network moves gated by the interlock output.
wire ilk_ok = ~I_INTERLOCK_EN | I_INTERLOCK_DIGITAL_OUTPUT;
wire net_open = I_SEL_REMOTE & I_NET_OPEN & ilk_ok;
wire net_close = I_SEL_REMOTE & I_NET_CLOSE & ilk_ok;
wire loc_open = I_SEL_LOCAL & I_LOCAL_OPEN;
wire loc_close = I_SEL_LOCAL & I_LOCAL_CLOSE;

// [R11] Shutdown from any source.
wire esd_req = aux_esd | (I_SEL_REMOTE & I_NET_EMERGENCY_SHUTDOWN);

wire any_open = loc_open | ((aux_open | net_open) & ~aux_stop);
wire any_close = loc_close | ((aux_close | net_close) & ~aux_stop);
wire any_cmd = any_open | any_close;

// Opposing requests cancel so the motor never gets both directions.
wire req_open = esd_req ? I_ESD_OPEN_DIR : (any_open & ~any_close);
wire req_close = esd_req ? ~I_ESD_OPEN_DIR : (any_close & ~any_open);

// =====================================================================
// Thermostat inhibit
// =====================================================================

reg thermo_block_reg;
reg thermo_block_next;

// [R18] The block lifts only after reset with no command held.
always @* begin
	thermo_block_next = thermo_block_reg;
	if (~I_THERMO_CLOSED)
		thermo_block_next = 1'b1;
	else if (~any_cmd)
		thermo_block_next = 1'b0;
end

always @(posedge I_CLK) begin
	if (I_SYS_RST)
		thermo_block_reg <= 1'b0;
	else
		thermo_block_reg <= thermo_block_next;
end

// [R17] [R19] Trip stops the motor unless shutdown may override.
wire thermo_stop = (~I_THERMO_CLOSED | thermo_block_reg) &
	~(esd_req & I_ESD_OVERRIDE_THERMO);
wire drive_open = req_open & ~thermo_stop;
wire drive_close = req_close & ~thermo_stop;

// =====================================================================
// Interrupter timer
// =====================================================================

reg [1:0] int_state_reg;
reg [1:0] int_state_next;
reg tmr_start;
reg [SEC_W-1:0] tmr_secs;
wire tmr_done;
wire [SEC_W-1:0] on_sec;
wire [SEC_W-1:0] off_sec;

// Clamp a period to the range of the active setting source.
function [SEC_W-1:0] clamp_sec;
	input [SEC_W-1:0] val;
	input ext;
	reg [SEC_W-1:0] hi;
	begin
		// [R5] [R6] Local or extended range.
		hi = ext ? `AASF_INT_EXT_MAX : `AASF_INT_LOCAL_MAX;
		if (val < `AASF_INT_LOCAL_MIN)
			clamp_sec = `AASF_INT_LOCAL_MIN;
		else if (val > hi)
			clamp_sec = hi;
		else
			clamp_sec = val;
	end
endfunction

assign on_sec = clamp_sec(I_INT_ON_SEC, I_INT_EXT_RANGE);
assign off_sec = clamp_sec(I_INT_OFF_SEC, I_INT_EXT_RANGE);

// [R4] Zone per direction; opening from a start point upward.
wire int_zone = I_INT_EN & (esd_req == 1'b0) &
	((drive_open & (I_POSITION_PCT >= I_INT_OPEN_START_PCT)) |
	(drive_close & (I_POSITION_PCT <= I_INT_CLOSE_START_PCT)));

// [R4] Alternating on and dwell phases.
always @* begin
	int_state_next = int_state_reg;
	tmr_start = 1'b0;
	tmr_secs = on_sec;
	case (int_state_reg)
	`AASF_ST_IDLE: begin
		if (int_zone) begin
			int_state_next = `AASF_ST_ON;
			tmr_start = 1'b1;
		end
	end
	`AASF_ST_ON: begin
		if (~int_zone) begin
			int_state_next = `AASF_ST_IDLE;
		end else if (tmr_done) begin
			int_state_next = `AASF_ST_DWELL;
			tmr_start = 1'b1;
			tmr_secs = off_sec;
		end
	end
	`AASF_ST_DWELL: begin
		if (~int_zone) begin
			int_state_next = `AASF_ST_IDLE;
		end else if (tmr_done) begin
			int_state_next = `AASF_ST_ON;
			tmr_start = 1'b1;
		end
	end
	default: begin
		int_state_next = `AASF_ST_IDLE;
	end
	endcase
end

always @(posedge I_CLK) begin
	if (I_SYS_RST)
		int_state_reg <= `AASF_ST_IDLE;
	else
		int_state_reg <= int_state_next;
end

aasf_period_timer #(
	.CLK_HZ(CLK_HZ),
	.SEC_W(SEC_W)
) u_period (
	.i_clk(I_CLK),
	.i_rst(I_SYS_RST),
	.i_start(tmr_start),
	.i_secs(tmr_secs),
	.o_done(tmr_done)
);

wire dwell = (int_state_reg == `AASF_ST_DWELL) & int_zone;
wire motor_open_next = drive_open & ~dwell;
wire motor_close_next = drive_close & ~dwell;

// =====================================================================
// Stall detection
// =====================================================================

reg [31:0] stall_cnt_reg;
reg [31:0] stall_cnt_next;
reg stall_next;
reg drive_d_reg;
wire driving = O_MOTOR_OPEN | O_MOTOR_CLOSE;
wire drive_rise = driving & ~drive_d_reg;
wire dir_change = (O_MOTOR_OPEN & ~motor_open_next & motor_close_next) |
	(O_MOTOR_CLOSE & ~motor_close_next & motor_open_next);

always @* begin
	stall_cnt_next = stall_cnt_reg;
	stall_next = O_STALLED;
	if (drive_rise | dir_change) begin
		// [R21] Fresh command restarts the window.
		stall_cnt_next = 32'h0000_0000;
		stall_next = 1'b0;
	end else if (I_MOVING) begin
		// [R21] Motion clears timer and flag.
		stall_cnt_next = 32'h0000_0000;
		stall_next = 1'b0;
	end else if (driving) begin
		// [R15] No motion for the full window.
		if (stall_cnt_reg >= STALL_CYCLES - 1)
			stall_next = 1'b1;
		else
			stall_cnt_next = stall_cnt_reg + 32'h0000_0001;
	end
end

always @(posedge I_CLK) begin
	if (I_SYS_RST) begin
		stall_cnt_reg <= 32'h0000_0000;
		drive_d_reg <= 1'b0;
	end else begin
		stall_cnt_reg <= stall_cnt_next;
		drive_d_reg <= driving;
	end
end

// =====================================================================
// Handwheel detection
// =====================================================================

reg [6:0] hw_ref_reg;
reg [6:0] hw_ref_next;
reg hw_next;
wire [6:0] hw_diff = (I_POSITION_PCT >= hw_ref_reg) ?
	(I_POSITION_PCT - hw_ref_reg) : (hw_ref_reg - I_POSITION_PCT);

// Reference follows powered travel and coast; manual travel counts after.
always @* begin
	hw_ref_next = hw_ref_reg;
	hw_next = O_HANDWHEEL;
	if (driving | drive_d_reg) begin
		hw_ref_next = I_POSITION_PCT;
		hw_next = 1'b0;
	end else if (hw_diff >= `AASF_HW_DELTA_PCT) begin
		// [R16] Manual travel threshold.
		hw_next = 1'b1;
	end
end

reg hw_init_reg;

always @(posedge I_CLK) begin
	if (I_SYS_RST) begin
		hw_ref_reg <= 7'h00;
		hw_init_reg <= 1'b0;
	end else if (~hw_init_reg) begin
		hw_ref_reg <= I_POSITION_PCT;
		hw_init_reg <= 1'b1;
	end else begin
		hw_ref_reg <= hw_ref_next;
	end
end

// =====================================================================
// Flag and motor registers
// =====================================================================

// [R13] Phase loss counts only with mains supervision.
wire phase_lost = I_MAINS_SUPV_EN & ~(&I_PHASE_OK);

always @(posedge I_CLK) begin
	if (I_SYS_RST) begin
		O_MOTOR_OPEN <= 1'b0;
		O_MOTOR_CLOSE <= 1'b0;
		O_AUX_STATUS <= 4'h0;
		O_INTERRUPTER <= 1'b0;
		O_BLINKER <= 1'b0;
		O_INTERLOCK <= 1'b0;
		O_EMERGENCY_SHUTDOWN <= 1'b0;
		O_CTRL_NOT_AVAIL <= 1'b0;
		O_LOW_BATTERY <= 1'b0;
		O_STALLED <= 1'b0;
		O_HANDWHEEL <= 1'b0;
		O_THERMOSTAT <= 1'b0;
	end else begin
		// [R17] Motor drive after all gating.
		O_MOTOR_OPEN <= motor_open_next;
		O_MOTOR_CLOSE <= motor_close_next;
		// [R3] Closed contact reads true.
		O_AUX_STATUS <= I_AUX_CONTACT;
		// [R7] Dwell flag.
		O_INTERRUPTER <= dwell;
		// [R8] Flasher mirror.
		O_BLINKER <= I_FLASHER;
		// [R10] Interlock active.
		O_INTERLOCK <= I_INTERLOCK_EN & I_INTERLOCK_DIGITAL_OUTPUT;
		// [R11] Shutdown flag.
		O_EMERGENCY_SHUTDOWN <= esd_req;
		// [R12] [R13] Composite unavailable flag.
		O_CTRL_NOT_AVAIL <= I_SEL_LOCAL | I_SEL_LOCAL_STOP |
			~I_THERMO_CLOSED | phase_lost;
		// [R14] Battery comparator.
		O_LOW_BATTERY <= I_BATTERY_BELOW;
		O_STALLED <= stall_next;
		O_HANDWHEEL <= hw_next & hw_init_reg;
		// [R20] Held while the contact stays open.
		O_THERMOSTAT <= ~I_THERMO_CLOSED;
	end
end

endmodule

//--- test/aasf_flags_checker.sv
// Concurrent checks on the ports of the status and alarm flag block.
`timescale 1ns/100ps
module aasf_flags_checker (
	input wire I_CLK,
	input wire I_SYS_RST,
	input wire [3:0] I_AUX_CONTACT,
	input wire I_SEL_REMOTE,
	input wire I_SEL_LOCAL,
	input wire I_SEL_LOCAL_STOP,
	input wire I_NET_EMERGENCY_SHUTDOWN,
	input wire I_ESD_OVERRIDE_THERMO,
	input wire I_THERMO_CLOSED,
	input wire I_BATTERY_BELOW,
	input wire I_FLASHER,
	input wire I_MOVING,
	input wire O_MOTOR_OPEN,
	input wire O_MOTOR_CLOSE,
	input wire [3:0] O_AUX_STATUS,
	input wire O_BLINKER,
	input wire O_EMERGENCY_SHUTDOWN,
	input wire O_CTRL_NOT_AVAIL,
	input wire O_LOW_BATTERY,
	input wire O_STALLED,
	input wire O_THERMOSTAT
);
	// ==========================================================
	// Flag and drive relations
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	a_aux_status_lag: assert property ( // contact report
		!$past(I_SYS_RST) |-> O_AUX_STATUS == $past(I_AUX_CONTACT))
		else $error("aux status does not follow contacts");
	a_motor_one_way: assert property ( // single direction
		!(O_MOTOR_OPEN && O_MOTOR_CLOSE))
		else $error("motor driven both ways");
	a_thermo_trip_stop: assert property ( // trip stop
		!$past(I_SYS_RST) && !$past(I_THERMO_CLOSED)
		&& !$past(I_ESD_OVERRIDE_THERMO) |-> O_THERMOSTAT
		&& O_CTRL_NOT_AVAIL && !O_MOTOR_OPEN && !O_MOTOR_CLOSE)
		else $error("thermostat trip not handled");
	a_cna_local_sel: assert property ( // local selector
		!$past(I_SYS_RST) && $past(I_SEL_LOCAL || I_SEL_LOCAL_STOP)
		|-> O_CTRL_NOT_AVAIL) else $error("local not flagged");
	a_low_batt_flag: assert property ( // battery level
		!$past(I_SYS_RST) |-> O_LOW_BATTERY == $past(I_BATTERY_BELOW))
		else $error("battery flag wrong");
	a_blinker_state: assert property ( // flasher mirror
		!$past(I_SYS_RST) |-> O_BLINKER == $past(I_FLASHER))
		else $error("blinker flag wrong");
	a_stall_clear: assert property ( // motion clears
		!$past(I_SYS_RST) && $past(I_MOVING) |-> !O_STALLED)
		else $error("stall flag kept while moving");
	a_esd_net_flag: assert property ( // shutdown flag
		!$past(I_SYS_RST)
		&& $past(I_SEL_REMOTE && I_NET_EMERGENCY_SHUTDOWN)
		|-> O_EMERGENCY_SHUTDOWN) else $error("shutdown not flagged");
endmodule

bind aasf_status_flags aasf_flags_checker chk_u (.I_CLK(I_CLK),
	.I_SYS_RST(I_SYS_RST), .I_AUX_CONTACT(I_AUX_CONTACT),
	.I_SEL_REMOTE(I_SEL_REMOTE), .I_SEL_LOCAL(I_SEL_LOCAL),
	.I_SEL_LOCAL_STOP(I_SEL_LOCAL_STOP),
	.I_NET_EMERGENCY_SHUTDOWN(I_NET_EMERGENCY_SHUTDOWN),
	.I_ESD_OVERRIDE_THERMO(I_ESD_OVERRIDE_THERMO),
	.I_THERMO_CLOSED(I_THERMO_CLOSED), .I_BATTERY_BELOW(I_BATTERY_BELOW),
	.I_FLASHER(I_FLASHER), .I_MOVING(I_MOVING),
	.O_MOTOR_OPEN(O_MOTOR_OPEN), .O_MOTOR_CLOSE(O_MOTOR_CLOSE),
	.O_AUX_STATUS(O_AUX_STATUS), .O_BLINKER(O_BLINKER),
	.O_EMERGENCY_SHUTDOWN(O_EMERGENCY_SHUTDOWN),
	.O_CTRL_NOT_AVAIL(O_CTRL_NOT_AVAIL), .O_LOW_BATTERY(O_LOW_BATTERY),
	.O_STALLED(O_STALLED), .O_THERMOSTAT(O_THERMOSTAT));

//--- test/aasf_plant_model.sv
// Behavioural model of the valve gearing, motion sensing and handwheel.
`timescale 1ns/100ps
module aasf_plant_model (
	input wire i_clk,
	input wire i_motor_open,
	input wire i_motor_close,
	input wire i_stuck,
	input wire i_hand,
	output reg o_moving,
	output reg [6:0] o_position
);
	initial begin
		o_moving = 1'b0;
		o_position = 7'h32;
	end
	// ==========================================================
	// Motion
	// A stuck valve never turns under the motor, so the stall timer sees no motion.
	always @(posedge i_clk) begin
		o_moving <= (i_motor_open | i_motor_close | i_hand) & ~i_stuck;
		if ((i_hand | (o_moving & i_motor_open)) && o_position < 7'h64)
			o_position <= o_position + 7'h01;
		else if (o_moving && i_motor_close && o_position > 7'h00)
			o_position <= o_position - 7'h01;
	end
endmodule

//--- test/actuator_status_alarm_flags_tb.sv
// Self-checking bench for the actuator status and alarm flag block.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module actuator_status_alarm_flags_tb;
	typedef struct packed {
		logic [3:0] aux, en, cmd, sel, inp, st, mot, flg;
	} aasf_row_t;
	logic clk = 1'b0, rst = 1'b1;
	logic [3:0] aux = 4'hf, aux_en = 4'h0;
	logic remote = 1'b1, local_sel = 1'b0, lstop = 1'b0;
	logic lo_open = 1'b0, lo_close = 1'b0, n_open = 1'b0, n_close = 1'b0;
	logic n_esd = 1'b0, ilk_en = 1'b0, ilk_do = 1'b0, esd_open = 1'b0;
	logic ovr = 1'b0, thermo = 1'b1, supv = 1'b0, bat = 1'b0, flash = 1'b0;
	logic int_en = 1'b0, stuck = 1'b0, hand = 1'b0, moving;
	logic ext = 1'b0;
	logic [13:0] off_s = 14'h0001;
	logic [2:0] phase = 3'h7;
	logic [6:0] pos;
	logic o_open, o_close, o_int, o_bl, o_ilk, o_esd, o_cna, o_lb, o_st;
	logic o_hw, o_th;
	logic [3:0] o_aux;
	int fails = 0, check_count = 0, cyc = 0, dwell_len = 0;
	aasf_row_t r;
	aasf_row_t rows [12] = '{32'h5004_2502, 32'h1104_0120, 32'h2204_0210,
		32'h5504_0500, 32'h8804_0811, 32'h8004_0800, 32'h0014_4014,
		32'h0022_0008, 32'h0082_0028, 32'h0042_0018, 32'h0081_0008,
		32'h0004_1011};

	aasf_status_flags #(.CLK_HZ(10), .STALL_CYCLES(20)) dut_u (.I_CLK(clk),
		.I_SYS_RST(rst), .I_AUX_CONTACT(aux), .I_AUX_CTRL_EN(aux_en),
		.I_SEL_REMOTE(remote), .I_SEL_LOCAL(local_sel),
		.I_SEL_LOCAL_STOP(lstop), .I_LOCAL_OPEN(lo_open),
		.I_LOCAL_CLOSE(lo_close), .I_NET_OPEN(n_open), .I_NET_CLOSE(n_close),
		.I_NET_EMERGENCY_SHUTDOWN(n_esd), .I_INTERLOCK_EN(ilk_en),
		.I_INTERLOCK_DIGITAL_OUTPUT(ilk_do), .I_ESD_OPEN_DIR(esd_open),
		.I_ESD_OVERRIDE_THERMO(ovr), .I_THERMO_CLOSED(thermo),
		.I_MAINS_SUPV_EN(supv), .I_PHASE_OK(phase), .I_BATTERY_BELOW(bat),
		.I_FLASHER(flash), .I_MOVING(moving), .I_POSITION_PCT(pos),
		.I_INT_EN(int_en), .I_INT_EXT_RANGE(ext),
		.I_INT_OPEN_START_PCT(7'h00), .I_INT_CLOSE_START_PCT(7'h64),
		.I_INT_ON_SEC(14'h0001), .I_INT_OFF_SEC(off_s),
		.O_MOTOR_OPEN(o_open), .O_MOTOR_CLOSE(o_close), .O_AUX_STATUS(o_aux),
		.O_INTERRUPTER(o_int), .O_BLINKER(o_bl), .O_INTERLOCK(o_ilk),
		.O_EMERGENCY_SHUTDOWN(o_esd), .O_CTRL_NOT_AVAIL(o_cna),
		.O_LOW_BATTERY(o_lb), .O_STALLED(o_st), .O_HANDWHEEL(o_hw),
		.O_THERMOSTAT(o_th));

	aasf_plant_model plant_u (.i_clk(clk), .i_motor_open(o_open),
		.i_motor_close(o_close), .i_stuck(stuck), .i_hand(hand),
		.o_moving(moving), .o_position(pos));

	initial begin
		forever #25 clk = ~clk;
	end

	task give_verdict;
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			give_verdict;
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		wait_n(2);
		`CHK(o_aux, 4'h0) // quiet in reset
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		aux <= 4'h0;
		wait_n(2);
		`CHK(o_hw, 1'b0) // no manual travel
		@(posedge clk);
		hand <= 1'b1;
		@(posedge clk);
		hand <= 1'b0;
		wait_n(3);
		`CHK(o_hw, 1'b1) // one percent moved
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			r = rows[i];
			{aux, aux_en} <= {r.aux, r.en};
			{lo_open, lo_close, n_open, n_close} <= r.cmd;
			{remote, local_sel, lstop} <= r.sel[2:0];
			{bat, flash, n_esd} <= r.inp[2:0];
			wait_n(3);
			`CHK(o_aux, r.st) // contact report
			`CHK({o_open, o_close}, r.mot[1:0]) // drive map
			`CHK({o_cna, o_lb, o_bl, o_esd}, r.flg)
		end
		@(posedge clk);
		{n_esd, stuck, n_open} <= 3'h3;
		wait_n(12);
		`CHK(o_st, 1'b0) // window not over
		wait_n(14);
		`CHK(o_st, 1'b1) // stall seen
		@(posedge clk);
		stuck <= 1'b0;
		wait_n(3);
		`CHK(o_st, 1'b0) // motion clears
		@(posedge clk);
		ilk_en <= 1'b1;
		wait_n(3);
		`CHK({o_open, o_ilk}, 2'h0) // held back
		@(posedge clk);
		ilk_do <= 1'b1;
		wait_n(3);
		`CHK({o_open, o_ilk}, 2'h3) // released
		@(posedge clk);
		{int_en, ext, off_s} <= {2'h3, 14'h0064};
		for (int k = 0; k < 40 && o_int !== 1'b1; k++)
			wait_n(1);
		`CHK({o_int, o_open}, 2'h2) // dwell
		while (o_int === 1'b1 && dwell_len < 32'h0000_044C) begin
			wait_n(1);
			dwell_len++;
		end
		// A 100 s dwell at 10 Hz plus one cycle for the sequencer to act on the registered timer done.
		`CHK(dwell_len, 32'h0000_03E9) // extended dwell kept
		wait_n(2);
		`CHK({o_int, o_open}, 2'h1) // pulse on
		@(posedge clk);
		{int_en, thermo} <= 2'h0;
		wait_n(2);
		`CHK({o_open, o_th, o_cna}, 3'h3) // trip
		@(posedge clk);
		thermo <= 1'b1;
		wait_n(2);
		`CHK({o_open, o_th}, 2'h0) // held command refused
		@(posedge clk);
		n_open <= 1'b0;
		@(posedge clk);
		n_open <= 1'b1;
		wait_n(2);
		`CHK(o_open, 1'b1) // fresh command
		@(posedge clk);
		{n_open, thermo, ovr, n_esd, esd_open} <= 5'h07;
		wait_n(2);
		`CHK({o_open, o_esd, o_th}, 3'h7) // shutdown override
		@(posedge clk);
		{thermo, ovr, n_esd, supv, phase} <= 7'h4d;
		wait_n(2);
		`CHK(o_cna, 1'b1) // lost phase
		give_verdict;
	end
endmodule
